// ### common/amp_seq_pkg.sv
// constants, types and register map for the amplifier start-up sequencer
package amp_seq_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 50;
  localparam int T_RST_HOLD_NS = 100000;
  localparam int T_RST_REL_NS = 13500000;
  localparam int T_TRIM_NS = 50000000;
  localparam int T_HOLDOFF_NS = 240000000;
  localparam int T_SD_BASE_NS = 1000000;
  localparam int T_PLOSS_NS = 2000000;
  localparam int T_RST_LOW_NS = 2000;
  localparam int T_MS_NS = 1000000;
  localparam int RST_HOLD_CYC = (T_RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REL_CYC = (T_RST_REL_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRIM_CYC = (T_TRIM_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLDOFF_CYC = (T_HOLDOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SD_BASE_CYC = (T_SD_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PLOSS_CYC = (T_PLOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_CYC = (T_MS_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // device registers
  // ****************************************
  localparam logic [7:0] ADDR_SYSCTL = 8'h05;
  localparam logic [7:0] ADDR_PWM_SS = 8'h1A;
  localparam logic [7:0] ADDR_TRIM = 8'h1B;
  localparam logic [7:0] VAL_SD_ENTER = 8'h40;
  localparam logic [7:0] VAL_SD_EXIT = 8'h00;
  localparam logic [7:0] VAL_TRIM = 8'h00;
  // ****************************************
  // controller registers
  // ****************************************
  localparam logic [1:0] OFS_CMD = 2'h0;
  localparam logic [1:0] OFS_TIME = 2'h1;
  localparam logic [1:0] OFS_WRITE = 2'h2;
  localparam logic [1:0] OFS_STATUS = 2'h3;
  localparam int CMD_START = 0;
  localparam int CMD_SD_ENTER = 1;
  localparam int CMD_SD_EXIT = 2;
  localparam int CMD_PWR_DOWN = 3;
  localparam int CMD_PWR_LOSS = 4;
  localparam logic [15:0] TIME_RESET = 16'h0000;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dev_wr_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RST_HOLD = 4'h1,
    S_RST_REL = 4'h2,
    S_TRIM_WR = 4'h3,
    S_TRIM_WAIT = 4'h4,
    S_CONFIG = 4'h5,
    S_EXIT_WR = 4'h6,
    S_EXIT_WAIT = 4'h7,
    S_RUN = 4'h8,
    S_ENTER_WR = 4'h9,
    S_ENTER_WAIT = 4'hA,
    S_SHUTDOWN = 4'hB,
    S_PLOSS = 4'hC,
    S_RST_LOW = 4'hD,
    S_OFF = 4'hE
  } seq_state_t;
endpackage

// ### rtl/amp_startup_shutdown_sequencer.sv
// host-side power-up, shutdown and power-down sequencer for the amplifier
module amp_startup_shutdown_sequencer #(
  parameter int RST_REL_CYC = amp_seq_pkg::RST_REL_CYC,
  parameter int TRIM_CYC = amp_seq_pkg::TRIM_CYC,
  parameter int HOLDOFF_CYC = amp_seq_pkg::HOLDOFF_CYC,
  parameter int SD_BASE_CYC = amp_seq_pkg::SD_BASE_CYC,
  parameter int PLOSS_CYC = amp_seq_pkg::PLOSS_CYC,
  parameter int MS_CYC = amp_seq_pkg::MS_CYC,
  parameter logic [7:0] VOL_FIRST = 8'h07,
  parameter logic [7:0] VOL_LAST = 8'h0A,
  parameter logic [7:0] MUTE_ADDR = 8'h06
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic reset_n,
  output logic power_down_n,
  output logic inputs_en,
  output logic dev_req,
  output amp_seq_pkg::dev_wr_t dev_wr,
  input wire logic dev_ack
);
  // ****************************************
  // checks
  // ****************************************
  // refused at elaboration: a zero wait would wrap its down-counter to the top
  if (RST_REL_CYC < 1 || TRIM_CYC < 1 || HOLDOFF_CYC < 1 || SD_BASE_CYC < 1 ||
      PLOSS_CYC < 1 || MS_CYC < 1 || VOL_FIRST > VOL_LAST) begin : g_param_check
    $error("sequencer parameters out of range");
  end
  // ****************************************
  // state
  // ****************************************
  amp_seq_pkg::seq_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] hold_reg, hold_next;
  logic first_reg, first_next;
  logic pd_reg, pd_next;
  logic err_reg, err_next;
  logic uw_reg, uw_next;
  amp_seq_pkg::dev_wr_t uwd_reg, uwd_next;
  logic [15:0] time_reg, time_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rstn_reg, rstn_next;
  logic pdn_reg, pdn_next;
  logic inen_reg, inen_next;
  logic req_reg, req_next;
  amp_seq_pkg::dev_wr_t dwr_reg, dwr_next;
  logic [31:0] start_cyc, stop_cyc;
  logic [4:0] cmd;
  logic done, allowed, busy;

  // time register: start ms low byte, stop ms high byte, as decoded from pwm_start_stop_period
  // scaled as 1.3 x ms, rounded up to whole cycles
  always_comb begin
    start_cyc = ({24'h000000, time_reg[7:0]} * 32'd13 * MS_CYC + 32'd9) / 32'd10;
    stop_cyc = ({24'h000000, time_reg[15:8]} * 32'd13 * MS_CYC + 32'd9) / 32'd10;
  end

  assign cmd = (wr && addr == amp_seq_pkg::OFS_CMD) ? wdata[4:0] : 5'h00;
  assign done = req_reg && dev_ack;
  assign busy = req_reg || uw_reg;
  // volume and soft-mute only while running
  assign allowed = (uwd_reg.addr >= VOL_FIRST && uwd_reg.addr <= VOL_LAST) ||
                   uwd_reg.addr == MUTE_ADDR;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg == 32'h0) ? 32'h0 : cnt_reg - 32'h1;
    hold_next = (hold_reg == 32'h0) ? 32'h0 : hold_reg - 32'h1;
    first_next = first_reg;
    pd_next = pd_reg;
    err_next = err_reg;
    uw_next = uw_reg;
    uwd_next = uwd_reg;
    time_next = time_reg;
    rstn_next = rstn_reg;
    pdn_next = pdn_reg;
    inen_next = inen_reg;
    req_next = req_reg && !dev_ack;
    dwr_next = dwr_reg;
    if (wr && addr == amp_seq_pkg::OFS_TIME) begin
      time_next = wdata;
    end
    if (wr && addr == amp_seq_pkg::OFS_CMD) begin
      err_next = 1'b0;
    end
    if (wr && addr == amp_seq_pkg::OFS_WRITE) begin
      if (uw_reg) begin
        err_next = 1'b1;
      end else begin
        uw_next = 1'b1;
        uwd_next = wdata;
      end
    end
    // a user write queued to the device
    if (uw_reg && !req_reg) begin
      if (state_reg == amp_seq_pkg::S_CONFIG || state_reg == amp_seq_pkg::S_SHUTDOWN) begin
        req_next = 1'b1;
        dwr_next = uwd_reg;
        uw_next = 1'b0;
      end else if (state_reg == amp_seq_pkg::S_RUN) begin
        uw_next = 1'b0;
        if (allowed) begin
          req_next = 1'b1;
          dwr_next = uwd_reg;
        end else begin
          err_next = 1'b1;
        end
      end
    end
    case (state_reg)
      amp_seq_pkg::S_IDLE, amp_seq_pkg::S_OFF: begin
        rstn_next = 1'b0;
        pdn_next = 1'b0;
        inen_next = 1'b0;
        pd_next = 1'b0;
        if (cmd[amp_seq_pkg::CMD_START]) begin
          state_next = amp_seq_pkg::S_RST_HOLD;
          cnt_next = 32'(amp_seq_pkg::RST_HOLD_CYC - 1);
          pdn_next = 1'b1;
          inen_next = 1'b1;
        end
      end
      amp_seq_pkg::S_RST_HOLD: begin
        if (cnt_reg == 32'h0) begin
          rstn_next = 1'b1;
          state_next = amp_seq_pkg::S_RST_REL;
          cnt_next = 32'(RST_REL_CYC - 1);
        end
      end
      amp_seq_pkg::S_RST_REL: begin
        if (cnt_reg == 32'h0) begin
          state_next = amp_seq_pkg::S_TRIM_WR;
          req_next = 1'b1;
          dwr_next = '{addr: amp_seq_pkg::ADDR_TRIM, data: amp_seq_pkg::VAL_TRIM};
        end
      end
      amp_seq_pkg::S_TRIM_WR: begin
        if (done) begin
          state_next = amp_seq_pkg::S_TRIM_WAIT;
          cnt_next = 32'(TRIM_CYC - 1);
          if (!first_reg) begin
            first_next = 1'b1;
            hold_next = 32'(HOLDOFF_CYC - 1) + start_cyc;
          end
        end
      end
      amp_seq_pkg::S_TRIM_WAIT: begin
        if (cnt_reg == 32'h0) begin
          state_next = amp_seq_pkg::S_CONFIG;
        end
      end
      amp_seq_pkg::S_CONFIG, amp_seq_pkg::S_SHUTDOWN: begin
        if (cmd[amp_seq_pkg::CMD_PWR_DOWN]) begin
          state_next = amp_seq_pkg::S_RST_LOW;
          cnt_next = 32'(amp_seq_pkg::RST_LOW_CYC - 1);
          rstn_next = 1'b0;
        end else if (cmd[amp_seq_pkg::CMD_SD_EXIT]) begin
          state_next = amp_seq_pkg::S_EXIT_WR;
        end else if (cmd[amp_seq_pkg::CMD_SD_ENTER]) begin
          err_next = 1'b1;
        end
      end
      amp_seq_pkg::S_EXIT_WR: begin
        // hold-off, and queued configuration writes, drain first
        if (!busy && hold_reg == 32'h0 && !req_next) begin
          req_next = 1'b1;
          dwr_next = '{addr: amp_seq_pkg::ADDR_SYSCTL, data: amp_seq_pkg::VAL_SD_EXIT};
          state_next = amp_seq_pkg::S_EXIT_WAIT;
          cnt_next = 32'hFFFFFFFF;
        end
      end
      amp_seq_pkg::S_EXIT_WAIT: begin
        if (done) begin
          cnt_next = 32'(SD_BASE_CYC - 1) + start_cyc;
        end else if (!req_reg && cnt_reg == 32'h0) begin
          state_next = amp_seq_pkg::S_RUN;
        end
      end
      amp_seq_pkg::S_RUN: begin
        if (cmd[amp_seq_pkg::CMD_PWR_DOWN] || cmd[amp_seq_pkg::CMD_SD_ENTER]) begin
          pd_next = cmd[amp_seq_pkg::CMD_PWR_DOWN];
          state_next = amp_seq_pkg::S_ENTER_WR;
        end else if (cmd[amp_seq_pkg::CMD_SD_EXIT]) begin
          err_next = 1'b1;
        end
      end
      amp_seq_pkg::S_ENTER_WR: begin
        if (!busy && hold_reg == 32'h0 && !req_next) begin
          req_next = 1'b1;
          dwr_next = '{addr: amp_seq_pkg::ADDR_SYSCTL, data: amp_seq_pkg::VAL_SD_ENTER};
          state_next = amp_seq_pkg::S_ENTER_WAIT;
          cnt_next = 32'hFFFFFFFF;
        end
      end
      amp_seq_pkg::S_ENTER_WAIT: begin
        if (done) begin
          cnt_next = 32'(SD_BASE_CYC - 1) + stop_cyc;
        end else if (!req_reg && cnt_reg == 32'h0) begin
          if (pd_reg) begin
            state_next = amp_seq_pkg::S_RST_LOW;
            cnt_next = 32'(amp_seq_pkg::RST_LOW_CYC - 1);
            rstn_next = 1'b0;
          end else begin
            state_next = amp_seq_pkg::S_SHUTDOWN;
          end
        end
      end
      amp_seq_pkg::S_PLOSS: begin
        if (cnt_reg == 32'h0) begin
          state_next = amp_seq_pkg::S_RST_LOW;
          cnt_next = 32'(amp_seq_pkg::RST_LOW_CYC - 1);
          rstn_next = 1'b0;
        end
      end
      amp_seq_pkg::S_RST_LOW: begin
        if (cnt_reg == 32'h0) begin
          inen_next = 1'b0;
          pdn_next = 1'b0;
          state_next = amp_seq_pkg::S_OFF;
        end
      end
      default: begin
        state_next = amp_seq_pkg::S_IDLE;
      end
    endcase
    // sudden power loss overrides any step but S_IDLE, S_OFF, S_PLOSS and S_RST_LOW; a write in flight is abandoned
    if (cmd[amp_seq_pkg::CMD_PWR_LOSS] && state_reg != amp_seq_pkg::S_IDLE &&
        state_reg != amp_seq_pkg::S_OFF && state_reg != amp_seq_pkg::S_RST_LOW &&
        state_reg != amp_seq_pkg::S_PLOSS) begin
      state_next = amp_seq_pkg::S_PLOSS;
      pdn_next = 1'b0;
      cnt_next = 32'(PLOSS_CYC - 1);
      req_next = 1'b0;
      uw_next = 1'b0;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    rdata_next = 16'h0000;
    if (rd) begin
      case (addr)
        amp_seq_pkg::OFS_TIME: rdata_next = time_reg;
        amp_seq_pkg::OFS_WRITE: rdata_next = uwd_reg;
        amp_seq_pkg::OFS_STATUS: begin
          rdata_next = {8'h00, hold_reg != 32'h0, first_reg, busy, err_reg, state_reg};
        end
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= amp_seq_pkg::S_IDLE;
      cnt_reg <= 32'h0;
      hold_reg <= 32'h0;
      first_reg <= 1'b0;
      pd_reg <= 1'b0;
      err_reg <= 1'b0;
      uw_reg <= 1'b0;
      uwd_reg <= '0;
      time_reg <= amp_seq_pkg::TIME_RESET;
      rdata_reg <= 16'h0000;
      rstn_reg <= 1'b0;
      pdn_reg <= 1'b0;
      inen_reg <= 1'b0;
      req_reg <= 1'b0;
      dwr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      first_reg <= first_next;
      pd_reg <= pd_next;
      err_reg <= err_next;
      uw_reg <= uw_next;
      uwd_reg <= uwd_next;
      time_reg <= time_next;
      rdata_reg <= rdata_next;
      rstn_reg <= rstn_next;
      pdn_reg <= pdn_next;
      inen_reg <= inen_next;
      req_reg <= req_next;
      dwr_reg <= dwr_next;
    end
  end

  assign rdata = rdata_reg;
  assign reset_n = rstn_reg;
  assign power_down_n = pdn_reg;
  assign inputs_en = inen_reg;
  assign dev_req = req_reg;
  assign dev_wr = dwr_reg;
endmodule

// ### tb/amp_seq_monitor.sv
// port checker for the amplifier start-up sequencer
module amp_seq_monitor #(
  parameter int RST_REL_CYC = 20,
  parameter int HOLDOFF_CYC = 50,
  parameter int PLOSS_CYC = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic reset_n,
  input wire logic power_down_n,
  input wire logic inputs_en,
  input wire logic dev_req,
  input wire amp_seq_pkg::dev_wr_t dev_wr,
  input wire logic dev_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // helper counters
  // ****************************************
  // 24 bits outlast any run, so no saturation is needed
  logic [23:0] hold_reg;
  logic [23:0] high_reg;
  logic [23:0] loss_reg;
  logic [23:0] low_reg;
  logic [23:0] trim_reg;
  logic trim_done_reg;
  logic first_trim;
  assign first_trim = dev_req && dev_ack && dev_wr.addr == amp_seq_pkg::ADDR_TRIM && !trim_done_reg;
  always_ff @(posedge mclk) begin
    hold_reg <= (!reset_n && power_down_n) ? hold_reg + 24'h1 : 24'h0;
    high_reg <= reset_n ? high_reg + 24'h1 : 24'h0;
    loss_reg <= (reset_n && !power_down_n) ? loss_reg + 24'h1 : 24'h0;
    low_reg <= !reset_n ? low_reg + 24'h1 : 24'h0;
    trim_reg <= trim_reg + 24'h1;
    if (rst) begin
      trim_done_reg <= 1'b0;
    end else if (first_trim) begin
      trim_done_reg <= 1'b1;
      trim_reg <= 24'h0;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence trim_req_s;
    $rose(dev_req) && dev_wr.addr == amp_seq_pkg::ADDR_TRIM;
  endsequence
  sequence sd_req_s;
    $rose(dev_req) && dev_wr.addr == amp_seq_pkg::ADDR_SYSCTL;
  endsequence
  AST_RST_OUTS: assert property ($fell(rst) |-> !reset_n && !power_down_n && !inputs_en && !dev_req)
    else $error("outputs not low after reset");
  AST_HOLD_RESET: assert property ($rose(reset_n) |-> power_down_n && hold_reg >= amp_seq_pkg::RST_HOLD_CYC)
    else $error("reset released too early");
  AST_TRIM_WAIT: assert property (trim_req_s |-> high_reg >= RST_REL_CYC && dev_wr.data == amp_seq_pkg::VAL_TRIM)
    else $error("trim issued too early or with wrong value");
  AST_SD_HOLDOFF: assert property (sd_req_s |-> trim_done_reg && trim_reg >= HOLDOFF_CYC)
    else $error("shutdown write inside first-trim hold-off");
  AST_PLOSS: assert property ($fell(reset_n) && !power_down_n |-> loss_reg >= PLOSS_CYC)
    else $error("reset asserted too soon after power loss");
  AST_INPUTS_LOW: assert property ($fell(inputs_en) |-> !reset_n && low_reg >= amp_seq_pkg::RST_LOW_CYC)
    else $error("inputs dropped before reset held low long enough");
  AST_ACK_DROP: assert property (dev_req && dev_ack |=> !dev_req)
    else $error("request held after acknowledge");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule

bind amp_startup_shutdown_sequencer amp_seq_monitor #(.RST_REL_CYC(RST_REL_CYC), .HOLDOFF_CYC(HOLDOFF_CYC),
  .PLOSS_CYC(PLOSS_CYC)) mon_u (.mclk(mclk), .rst(rst), .rd(rd), .rdata(rdata), .reset_n(reset_n),
  .power_down_n(power_down_n), .inputs_en(inputs_en), .dev_req(dev_req), .dev_wr(dev_wr), .dev_ack(dev_ack));

// ### tb/amp_device_model.sv
// behavioural amplifier register file behind the write link
module amp_device_model #(
  parameter int HOLDOFF_CYC = 50
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic dev_req,
  input wire amp_seq_pkg::dev_wr_t dev_wr,
  input wire logic [3:0] ack_delay,
  output logic dev_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sysctl_reg;
  logic [7:0] pwm_ss_reg;
  logic [7:0] trim_reg;
  logic [7:0] last_reg;
  logic [3:0] wait_reg;
  logic [23:0] since_reg;
  logic first_reg;
  always_ff @(posedge mclk) begin
    since_reg <= since_reg + 24'h1;
    if (rst) begin
      first_reg <= 1'b0;
    end
    if (rst || !reset_n) begin
      // FF marks a register never written since reset, arbitrary
      dev_ack <= 1'b0;
      wait_reg <= 4'h0;
      sysctl_reg <= 8'hFF;
      pwm_ss_reg <= 8'hFF;
      trim_reg <= 8'hFF;
      last_reg <= 8'hFF;
    end else begin
      dev_ack <= dev_req && !dev_ack && wait_reg + 4'h1 >= ack_delay;
      wait_reg <= (dev_req && !dev_ack) ? wait_reg + 4'h1 : 4'h0;
      if (dev_req && dev_ack) begin
        last_reg <= dev_wr.addr;
        if (dev_wr.addr == amp_seq_pkg::ADDR_TRIM) begin
          trim_reg <= dev_wr.data;
          first_reg <= 1'b1;
          if (!first_reg) since_reg <= 24'h0;
        end
        if (dev_wr.addr == amp_seq_pkg::ADDR_PWM_SS) pwm_ss_reg <= dev_wr.data;
        // an early exit is dropped, as the real part may do
        if (dev_wr.addr == amp_seq_pkg::ADDR_SYSCTL && !(first_reg && since_reg < HOLDOFF_CYC &&
            dev_wr.data == amp_seq_pkg::VAL_SD_EXIT)) sysctl_reg <= dev_wr.data;
      end
    end
  end
endmodule

// ### tb/amp_startup_shutdown_sequencer_tb_top.sv
// self-checking bench for the amplifier start-up sequencer
module amp_startup_shutdown_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] st;
  logic [3:0] ack_delay = 4'h1;
  logic reset_n, power_down_n, inputs_en, dev_req, dev_ack;
  amp_seq_pkg::dev_wr_t dev_wr;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  // short waits keep the run small; one value feeds both sides of the link
  localparam int REL_CYC = 20;
  localparam int TRIM_WAIT_CYC = 30;
  localparam int HOLD_CYC = 50;
  localparam int BASE_CYC = 10;
  localparam int LOSS_CYC = 10;
  localparam int MSEC_CYC = 5;
  amp_startup_shutdown_sequencer #(.RST_REL_CYC(REL_CYC), .TRIM_CYC(TRIM_WAIT_CYC), .HOLDOFF_CYC(HOLD_CYC),
    .SD_BASE_CYC(BASE_CYC), .PLOSS_CYC(LOSS_CYC), .MS_CYC(MSEC_CYC)) dut_u (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .reset_n(reset_n), .power_down_n(power_down_n), .inputs_en(inputs_en), .dev_req(dev_req),
    .dev_wr(dev_wr), .dev_ack(dev_ack));
  amp_device_model #(.HOLDOFF_CYC(HOLD_CYC)) dev_m (.mclk(mclk), .rst(rst), .reset_n(reset_n), .dev_req(dev_req),
    .dev_wr(dev_wr), .ack_delay(ack_delay), .dev_ack(dev_ack));
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_st();
    @(posedge mclk);
    addr <= amp_seq_pkg::OFS_STATUS;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    st = rdata;
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    st = 16'hFFFF;
    for (int i = 0; i < lim && st[3:0] !== s; i++) rd_st();
    chk("state", {12'h000, s}, {12'h000, st[3:0]});
  endtask
  task automatic wait_ack();
    for (int i = 0; i < 200 && !(dev_req && dev_ack); i++) @(posedge mclk);
    chk("ack", 16'h0001, {15'h0000, dev_req && dev_ack});
  endtask
  task automatic cmd(input int c);
    wr_reg(amp_seq_pkg::OFS_CMD, 16'h0001 << c);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_powerup();
    #1;
    chk("pins idle", 16'h0000, {13'h0000, reset_n, power_down_n, inputs_en});
    wr_reg(amp_seq_pkg::OFS_TIME, 16'h0203);
    cmd(amp_seq_pkg::CMD_START);
    #1;
    chk("pins hold", 16'h0003, {13'h0000, reset_n, power_down_n, inputs_en});
    wait_st(amp_seq_pkg::S_CONFIG, 1500);
    chk("trim", 16'h0000, {8'h00, dev_m.trim_reg});
    chk("first trim", 16'h0001, {15'h0000, st[6]});
  endtask
  task automatic t_exit();
    // slow partner while configuring
    ack_delay <= 4'h6;
    wr_reg(amp_seq_pkg::OFS_WRITE, 16'h1A23);
    wait_ack();
    cmd(amp_seq_pkg::CMD_SD_EXIT);
    wait_ack();
    chk("pwm", 16'h0023, {8'h00, dev_m.pwm_ss_reg});
    chk("exit word", {amp_seq_pkg::ADDR_SYSCTL, amp_seq_pkg::VAL_SD_EXIT}, dev_wr);
    repeat (24) @(posedge mclk);
    rd_st();
    chk("exit wait", 16'h0007, {12'h000, st[3:0]});
    wait_st(amp_seq_pkg::S_RUN, 40);
    chk("sysctl", 16'h0000, {8'h00, dev_m.sysctl_reg});
    ack_delay <= 4'h1;
  endtask
  task automatic t_run();
    wr_reg(amp_seq_pkg::OFS_WRITE, 16'h0811);
    wait_ack();
    @(posedge mclk);
    chk("volume", 16'h0008, {8'h00, dev_m.last_reg});
    wr_reg(amp_seq_pkg::OFS_WRITE, 16'h1B00);
    rd_st();
    chk("refused", 16'h0010, st & 16'h0030);
  endtask
  task automatic t_shutdown();
    cmd(amp_seq_pkg::CMD_SD_ENTER);
    wait_ack();
    chk("enter word", {amp_seq_pkg::ADDR_SYSCTL, amp_seq_pkg::VAL_SD_ENTER}, dev_wr);
    repeat (17) @(posedge mclk);
    rd_st();
    chk("enter wait", 16'h000A, {12'h000, st[3:0]});
    wait_st(amp_seq_pkg::S_SHUTDOWN, 40);
    wr_reg(amp_seq_pkg::OFS_WRITE, 16'h1A45);
    wait_ack();
    @(posedge mclk);
    chk("reconfig", 16'h0045, {8'h00, dev_m.pwm_ss_reg});
    cmd(amp_seq_pkg::CMD_PWR_DOWN);
    wait_st(amp_seq_pkg::S_OFF, 100);
    chk("pins off", 16'h0000, {13'h0000, reset_n, power_down_n, inputs_en});
  endtask
  task automatic t_pwr_run();
    cmd(amp_seq_pkg::CMD_START);
    wait_st(amp_seq_pkg::S_CONFIG, 1500);
    cmd(amp_seq_pkg::CMD_SD_ENTER);
    rd_st();
    chk("enter refused", 16'h0015, st & 16'h001F);
    cmd(amp_seq_pkg::CMD_SD_EXIT);
    wait_ack();
    wait_st(amp_seq_pkg::S_RUN, 40);
    cmd(amp_seq_pkg::CMD_SD_EXIT);
    rd_st();
    chk("exit refused", 16'h0018, st & 16'h001F);
    cmd(amp_seq_pkg::CMD_PWR_DOWN);
    wait_ack();
    chk("down word", {amp_seq_pkg::ADDR_SYSCTL, amp_seq_pkg::VAL_SD_ENTER}, dev_wr);
    wait_st(amp_seq_pkg::S_OFF, 100);
    chk("pins down", 16'h0000, {13'h0000, reset_n, power_down_n, inputs_en});
  endtask
  task automatic t_ploss();
    cmd(amp_seq_pkg::CMD_START);
    wait_st(amp_seq_pkg::S_CONFIG, 1500);
    chk("no rearm", 16'h0000, {15'h0000, st[7]});
    cmd(amp_seq_pkg::CMD_PWR_LOSS);
    @(posedge mclk);
    #1;
    chk("pins loss", 16'h0005, {13'h0000, reset_n, power_down_n, inputs_en});
    wait_st(amp_seq_pkg::S_OFF, 100);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_powerup();
    t_exit();
    t_run();
    t_shutdown();
    t_pwr_run();
    t_ploss();
    final_report();
  end
endmodule
